// ### design/stm_pkg.sv
// Functional notes
// - counter readable as low and high read-only bytes, zero after reset
// - compare A held in two read/write bytes, reset to zero
// - compare P byte matches counter bits 15..8 at P-1 with bits 7..0 at FF
// - mode 00, clear-select low: clear on P match or overflow, A and P flags
// - clear-select high: clear on A match, only A flag raised
// - compare A of zero with clear-select high: counter rolls over at FFFF, no A flag
// - compare-match mode: pin changes only on A match, never on P
// - on A match pin follows pin-function: hold, low, high, toggle
// - enable rising edge loads pin with output-control initial level, inverted in PWM except single pulse
// - mode 11 counts and flags like compare-match, pin left unused
// - PWM: duty/period select picks comparators, clear-select ignored
// - select 0: period P*256 or 65536, duty A, full when duty>=period
// - select 1: period from A, duty P*256 or 65536
// - PWM raises A flag on A match and, except in single pulse, P flag on P match
// - PWM: output-control sets polarity, pin-function forces, invert flips pin
// - PWM counting and flags continue while pin forced by codes 00/01
// - single pulse: enable rising edge starts counter and pulse
// - single pulse: A match clears enable, ends pulse; software clear ends too
// - 3-bit clock select: sys/4, sys, high/16, high/64, sub, reserved
// - enable rising edge zeroes counter; enable low stops, keeps value
// - pause bit freezes counter; clearing resumes from held value
package stm_pkg;
  // word byte addresses
  localparam logic [3:0] ADDR_CTRL0   = 4'h0;
  localparam logic [3:0] ADDR_CTRL1   = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO  = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI  = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
  localparam logic [3:0] ADDR_CMPP    = 4'h6;
  localparam logic [3:0] ADDR_FLAGS   = 4'h7;
  // control 0 fields
  localparam int CTRL0_PAUSE  = 7;
  localparam int CTRL0_CLK_HI = 6;
  localparam int CTRL0_CLK_LO = 4;
  localparam int CTRL0_ENABLE = 3;
  localparam logic [7:0] CTRL0_MASK = 8'hF8;
  // control 1 fields
  localparam int CTRL1_MODE_HI = 7;
  localparam int CTRL1_MODE_LO = 6;
  localparam int CTRL1_PIN_HI  = 5;
  localparam int CTRL1_PIN_LO  = 4;
  localparam int CTRL1_OCTRL   = 3;
  localparam int CTRL1_INVERT  = 2;
  localparam int CTRL1_DPX     = 1;
  localparam int CTRL1_CLRSEL  = 0;
  // flags register fields
  localparam int FLAG_A = 0;
  localparam int FLAG_P = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // pin-function codes
  localparam logic [1:0] PIN_HOLD   = 2'h0;
  localparam logic [1:0] PIN_LOW    = 2'h1;
  localparam logic [1:0] PIN_HIGH   = 2'h2;
  localparam logic [1:0] PIN_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_INACT  = 2'h0;
  localparam logic [1:0] PWM_ACT    = 2'h1;
  localparam logic [1:0] PWM_WAVE   = 2'h2;
  localparam logic [1:0] PWM_SINGLE = 2'h3;
  // clock selects
  localparam logic [2:0] CLK_SYS4  = 3'h0;
  localparam logic [2:0] CLK_SYS   = 3'h1;
  localparam logic [2:0] CLK_H16   = 3'h2;
  localparam logic [2:0] CLK_H64   = 3'h3;
  localparam logic [2:0] CLK_SUB0  = 3'h4;
  localparam logic [2:0] CLK_SUB1  = 3'h5;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV16_LAST = 6'h0F;
  localparam logic [5:0] DIV64_LAST = 6'h3F;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage

// ### design/stm_timer.sv
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module stm_timer (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic [31:0]      AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  // clock sources
  input  wire logic        HCLK_TICK_IN,
  input  wire logic        SUBCLK_TICK_IN,
  // output pin
  output logic             TIMER_PIN_OUT,
  output logic             TIMER_PIN_OE_OUT,
  // match pulses
  output logic             MATCH_A_PULSE_OUT,
  output logic             MATCH_P_PULSE_OUT
);
  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [15:0] count_q;
  logic [15:0] cmpa_q;
  logic [7:0]  cmpp_q;
  logic        flag_a_q;
  logic        flag_p_q;
  logic        en_prev_q;
  logic        pin_q;
  logic        pin_out_q;
  logic        oe_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [5:0]  sys_div_q;
  logic [5:0]  h_div_q;
  logic        pulse_a_q;
  logic        pulse_p_q;

  logic [1:0]  mode;
  logic [1:0]  pinf;
  logic        enable;
  logic        en_rise;
  logic        tick;
  logic        match_a;
  logic        match_p;
  logic        overflow;
  logic        clr_cnt;
  logic        raise_a;
  logic        raise_p;
  logic        single;
  logic        pwm_act;
  logic        wr_go;
  logic        rd_go;
  logic        wr_ctrl0;
  logic        pin_d;

  function automatic logic hit(input logic [3:0] a);
    hit = (AVS_ADDRESS_IN == a) && AVS_BYTEENABLE_IN[0];
  endfunction

  assign mode   = ctrl1_q[stm_pkg::CTRL1_MODE_HI:stm_pkg::CTRL1_MODE_LO];
  assign pinf   = ctrl1_q[stm_pkg::CTRL1_PIN_HI:stm_pkg::CTRL1_PIN_LO];
  assign enable = ctrl0_q[stm_pkg::CTRL0_ENABLE];
  assign single = (mode == stm_pkg::MODE_PWM) && (pinf == stm_pkg::PWM_SINGLE);
  assign wr_go  = AVS_WRITE_IN && !ack_q;
  assign rd_go  = AVS_READ_IN && !ack_q;
  assign wr_ctrl0 = wr_go && hit(stm_pkg::ADDR_CTRL0);

  // one-wait-state bus: request taken, answered next edge
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (rd_go || wr_go);
    end
  end
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;

  // read data captured when request taken
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_q <= 32'h0000_0000;
      unique case (AVS_ADDRESS_IN)
        stm_pkg::ADDR_CTRL0:   rdata_q[7:0] <= ctrl0_q;
        stm_pkg::ADDR_CTRL1:   rdata_q[7:0] <= ctrl1_q;
        stm_pkg::ADDR_CNT_LO:  rdata_q[7:0] <= count_q[7:0];
        stm_pkg::ADDR_CNT_HI:  rdata_q[7:0] <= count_q[15:8];
        stm_pkg::ADDR_CMPA_LO: rdata_q[7:0] <= cmpa_q[7:0];
        stm_pkg::ADDR_CMPA_HI: rdata_q[7:0] <= cmpa_q[15:8];
        stm_pkg::ADDR_CMPP:    rdata_q[7:0] <= cmpp_q;
        stm_pkg::ADDR_FLAGS:   rdata_q[1:0] <= {flag_p_q, flag_a_q};
        default:               rdata_q[7:0] <= 8'h00;
      endcase
    end
  end
  assign AVS_READDATA_OUT = rdata_q;

  // control 0; hardware clear of enable wins over a write
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl0_q <= stm_pkg::RESET_BYTE;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_q <= AVS_WRITEDATA_IN[7:0] & stm_pkg::CTRL0_MASK;
      end
      if (single && enable && raise_a) begin
        ctrl0_q[stm_pkg::CTRL0_ENABLE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl1_q <= stm_pkg::RESET_BYTE;
      cmpa_q  <= 16'h0000;
      cmpp_q  <= stm_pkg::RESET_BYTE;
    end else if (wr_go) begin
      if (hit(stm_pkg::ADDR_CTRL1)) begin
        ctrl1_q <= AVS_WRITEDATA_IN[7:0];
      end
      if (hit(stm_pkg::ADDR_CMPA_LO)) begin
        cmpa_q[7:0] <= AVS_WRITEDATA_IN[7:0];
      end
      if (hit(stm_pkg::ADDR_CMPA_HI)) begin
        cmpa_q[15:8] <= AVS_WRITEDATA_IN[7:0];
      end
      if (hit(stm_pkg::ADDR_CMPP)) begin
        cmpp_q <= AVS_WRITEDATA_IN[7:0];
      end
    end
  end

  // prescalers free-run so a tick phase never depends on enable
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sys_div_q <= 6'h00;
      h_div_q   <= 6'h00;
    end else begin
      sys_div_q <= (sys_div_q == stm_pkg::DIV4_LAST) ? 6'h00 : sys_div_q + 6'h01;
      if (HCLK_TICK_IN) begin
        h_div_q <= h_div_q + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (ctrl0_q[stm_pkg::CTRL0_CLK_HI:stm_pkg::CTRL0_CLK_LO])
      stm_pkg::CLK_SYS4: tick = (sys_div_q == stm_pkg::DIV4_LAST);
      stm_pkg::CLK_SYS:  tick = 1'b1;
      stm_pkg::CLK_H16:  tick = HCLK_TICK_IN && (h_div_q[3:0] == stm_pkg::DIV16_LAST[3:0]);
      stm_pkg::CLK_H64:  tick = HCLK_TICK_IN && (h_div_q == stm_pkg::DIV64_LAST);
      stm_pkg::CLK_SUB0: tick = SUBCLK_TICK_IN;
      stm_pkg::CLK_SUB1: tick = SUBCLK_TICK_IN;
      // reserved codes never tick
      default:           tick = 1'b0;
    endcase
  end

  assign en_rise = enable && !en_prev_q;
  // match on equality at a counting tick
  assign overflow = (count_q == stm_pkg::CNT_MAX);
  assign match_a  = (cmpa_q != 16'h0000) && (count_q == cmpa_q);
  // P against upper byte as P-1 with lower byte FF; zero means overflow
  // clear replaces the step into {P,00}, so the period is P*256 ticks
  assign match_p  = (cmpp_q == 8'h00) ? overflow :
                    ((count_q[15:8] == cmpp_q - 8'h01) && (count_q[7:0] == 8'hFF));

  always_comb begin
    clr_cnt = 1'b0;
    raise_a = 1'b0;
    raise_p = 1'b0;
    // held count must not match on the restart edge
    if (enable && !en_rise && !ctrl0_q[stm_pkg::CTRL0_PAUSE] && tick) begin
      if (single) begin
        raise_a = match_a;
        clr_cnt = 1'b0;
      end else if (mode == stm_pkg::MODE_PWM) begin
        raise_a = match_a;
        raise_p = match_p;
        clr_cnt = ctrl1_q[stm_pkg::CTRL1_DPX] ? match_a : match_p;
      end else if (ctrl1_q[stm_pkg::CTRL1_CLRSEL]) begin
        // clear on A, no P flag
        raise_a = match_a;
        clr_cnt = match_a;
      end else begin
        // clear on P or overflow; same for mode 11
        raise_a = match_a;
        raise_p = match_p;
        clr_cnt = match_p;
      end
    end
  end

  // counter: zero on enable rise, hold while off or paused
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      count_q   <= 16'h0000;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= enable;
      if (en_rise) begin
        count_q <= 16'h0000;
      end else if (enable && !ctrl0_q[stm_pkg::CTRL0_PAUSE] && tick) begin
        if (single && raise_a) begin
          count_q <= count_q;
        end else if (clr_cnt) begin
          count_q <= 16'h0000;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  // sticky flags: set wins over write-one-to-clear
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      if (raise_a) begin
        flag_a_q <= 1'b1;
      end else if (wr_go && hit(stm_pkg::ADDR_FLAGS) && AVS_WRITEDATA_IN[stm_pkg::FLAG_A]) begin
        flag_a_q <= 1'b0;
      end
      if (raise_p) begin
        flag_p_q <= 1'b1;
      end else if (wr_go && hit(stm_pkg::ADDR_FLAGS) && AVS_WRITEDATA_IN[stm_pkg::FLAG_P]) begin
        flag_p_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pulse_a_q <= 1'b0;
      pulse_p_q <= 1'b0;
    end else begin
      pulse_a_q <= raise_a;
      pulse_p_q <= raise_p;
    end
  end
  assign MATCH_A_PULSE_OUT = pulse_a_q;
  assign MATCH_P_PULSE_OUT = pulse_p_q;

  // active while below duty; duty>=period gives full
  always_comb begin
    if (ctrl1_q[stm_pkg::CTRL1_DPX]) begin
      pwm_act = (cmpp_q == 8'h00) ? 1'b1 : (count_q < {cmpp_q, 8'h00});
    end else begin
      pwm_act = (count_q < cmpa_q);
    end
  end

  // pin level before inversion
  always_comb begin
    pin_d = pin_q;
    if (en_rise) begin
      pin_d = (mode == stm_pkg::MODE_PWM) ? !ctrl1_q[stm_pkg::CTRL1_OCTRL] ^ single
                                          : ctrl1_q[stm_pkg::CTRL1_OCTRL];
    end else if (mode == stm_pkg::MODE_CMP) begin
      if (raise_a) begin
        unique case (pinf)
          stm_pkg::PIN_HOLD:   pin_d = pin_q;
          stm_pkg::PIN_LOW:    pin_d = 1'b0;
          stm_pkg::PIN_HIGH:   pin_d = 1'b1;
          stm_pkg::PIN_TOGGLE: pin_d = !pin_q;
        endcase
      end
    end else if (mode == stm_pkg::MODE_PWM) begin
      // force codes, waveform keeps running behind them
      unique case (pinf)
        stm_pkg::PWM_INACT:  pin_d = !ctrl1_q[stm_pkg::CTRL1_OCTRL];
        stm_pkg::PWM_ACT:    pin_d = ctrl1_q[stm_pkg::CTRL1_OCTRL];
        stm_pkg::PWM_WAVE:   pin_d = pwm_act ? ctrl1_q[stm_pkg::CTRL1_OCTRL]
                                             : !ctrl1_q[stm_pkg::CTRL1_OCTRL];
        // pulse ends when enable falls for any reason
        stm_pkg::PWM_SINGLE: pin_d = (enable && !raise_a) ? ctrl1_q[stm_pkg::CTRL1_OCTRL]
                                                          : !ctrl1_q[stm_pkg::CTRL1_OCTRL];
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_q     <= 1'b0;
      pin_out_q <= 1'b0;
    end else begin
      pin_q     <= pin_d;
      pin_out_q <= pin_d ^ (ctrl1_q[stm_pkg::CTRL1_INVERT] &&
                            ((mode == stm_pkg::MODE_CMP) || (mode == stm_pkg::MODE_PWM)));
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (mode == stm_pkg::MODE_CMP) || (mode == stm_pkg::MODE_PWM);
    end
  end
  assign TIMER_PIN_OE_OUT = oe_q;
  assign TIMER_PIN_OUT    = pin_out_q;
endmodule

// ### dv/stm_timer_assertions.sv
`timescale 1ns/1ps
module stm_timer_assertions (
  // clock and reset
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  // bus
  input wire logic [3:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0]  AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  // timer side
  input wire logic        HCLK_TICK_IN,
  input wire logic        SUBCLK_TICK_IN,
  input wire logic        TIMER_PIN_OUT,
  input wire logic        TIMER_PIN_OE_OUT,
  input wire logic        MATCH_A_PULSE_OUT,
  input wire logic        MATCH_P_PULSE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_req;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
  endsequence
  sequence s_ans;
    !AVS_WAITREQUEST_OUT;
  endsequence
  a_bus_one_wait: assert property (s_req |=> s_ans)
    else $error("request not answered after one wait state");
  a_new_req_waits: assert property ($rose(AVS_READ_IN) || $rose(AVS_WRITE_IN)
    |-> AVS_WAITREQUEST_OUT) else $error("new request answered without wait");
  a_idle_no_wait: assert property (!(AVS_READ_IN || AVS_WRITE_IN) |-> s_ans)
    else $error("waitrequest high while idle");
  a_rd_upper_zero: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
    |-> AVS_READDATA_OUT[31:8] == 24'h000000) else $error("read data upper bits set");
  a_unmapped_rd_zero: assert property (
    AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN[3]
    |-> AVS_READDATA_OUT == 32'h00000000)
    else $error("unmapped read not zero");
  a_rd_data_stands: assert property (!AVS_READ_IN |=> $stable(AVS_READDATA_OUT))
    else $error("read data changed without read");
  a_pulse_a_one: assert property (MATCH_A_PULSE_OUT |=> !MATCH_A_PULSE_OUT)
    else $error("match a pulse longer than one cycle");
  a_p_match_gap: assert property (MATCH_P_PULSE_OUT |=> !MATCH_P_PULSE_OUT [*8])
    else $error("match p pulses too close");
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wrq;
  logic        htick;
  logic        stick = 1'b0;
  logic        pin;
  logic        oe;
  logic        pa;
  logic        pp;
  logic [31:0] q;
  logic [31:0] q2;
  int          errors;
  int          n_compared;
  int          n;
  int          h;
  logic [2:0]  cks[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  int          per[6] = '{1024, 256, 4096, 16384, 512, 512};
  logic [7:0]  c1s[5] = '{8'hA9, 8'hA8, 8'hAC, 8'hAA, 8'h98};
  logic [15:0] as[5]  = '{16'h0040, 16'h0200, 16'h0040, 16'h0100, 16'h0040};
  logic [7:0]  ps[5]  = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h01};
  int          hs[5]  = '{64, 256, 192, 256, 256};
  stm_timer i_stm_timer (
    .CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wrq), .HCLK_TICK_IN(htick),
    .SUBCLK_TICK_IN(stick), .TIMER_PIN_OUT(pin), .TIMER_PIN_OE_OUT(oe),
    .MATCH_A_PULSE_OUT(pa), .MATCH_P_PULSE_OUT(pp)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // sub clock at half rate so its undivided tick path is really gated
  always @(posedge clk) stick <= ~stick;
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wrq !== 1'b0 && k < 40);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 40) chk("bus_timeout", 1, 0);
  endtask
  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdk(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask
  task automatic wait_p(input logic p, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while ((p ? pp : pa) !== 1'b1 && c < 40000);
    if (c >= 40000) chk("pulse_timeout", 1, 0);
  endtask
  task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
                     input logic [2:0] ck);
    wrt(stm_pkg::ADDR_CTRL0, 8'h00);
    wrt(stm_pkg::ADDR_CTRL1, c1);
    wrt(stm_pkg::ADDR_CMPA_LO, a[7:0]);
    wrt(stm_pkg::ADDR_CMPA_HI, a[15:8]);
    wrt(stm_pkg::ADDR_CMPP, p);
    wrt(stm_pkg::ADDR_FLAGS, 8'h03);
    wrt(stm_pkg::ADDR_CTRL0, {1'b0, ck, 4'h8});
  endtask
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wdat = 32'h00000000;
    htick = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rdk("reset_val", 4'(i), 32'h0);
    wrt(stm_pkg::ADDR_CMPA_LO, 8'hA5);
    wrt(stm_pkg::ADDR_CMPA_HI, 8'h3C);
    wrt(stm_pkg::ADDR_CMPP, 8'h7E);
    wrt(stm_pkg::ADDR_CNT_LO, 8'hFF);
    wrt(stm_pkg::ADDR_CNT_HI, 8'hFF);
    wrt(4'h9, 8'h55);
    rdk("a_lo", stm_pkg::ADDR_CMPA_LO, 32'hA5);
    rdk("a_hi", stm_pkg::ADDR_CMPA_HI, 32'h3C);
    rdk("p_byte", stm_pkg::ADDR_CMPP, 32'h7E);
    rdk("cnt_lo", stm_pkg::ADDR_CNT_LO, 32'h0);
    rdk("cnt_hi", stm_pkg::ADDR_CNT_HI, 32'h0);
    rdk("unmapped", 4'h9, 32'h0);
    // compare a kept nonzero in compare-match mode
    for (int i = 0; i < 6; i++) begin
      cfg(8'h30, 16'h0080, 8'h01, cks[i]);
      wait_p(1'b1, n);
      wait_p(1'b1, n);
      chk("p_period", n, per[i]);
    end
    rdk("flags_both", stm_pkg::ADDR_FLAGS, 32'h3);
    for (int c = 0; c < 4; c++) begin
      cfg({2'b00, 2'(c), c != 2, 3'b001}, 16'h0010, 8'h00, stm_pkg::CLK_SYS);
      @(posedge clk);
      chk("pin_init", pin, c != 2);
      chk("cmp_oe", oe, 1);
      wait_p(1'b0, n);
      @(posedge clk);
      chk("pin_match1", pin, c == 0 || c == 2);
      wait_p(1'b0, n);
      @(posedge clk);
      chk("pin_match2", pin, c != 1);
      rdk("flags_a_only", stm_pkg::ADDR_FLAGS, 32'h1);
    end
    cfg(8'hC0, 16'h0000, 8'h10, stm_pkg::CLK_SYS);
    @(posedge clk);
    chk("tmr_oe", oe, 0);
    wait_p(1'b1, n);
    wait_p(1'b1, n);
    chk("tmr_period", n, 4096);
    rdk("flags_p_only", stm_pkg::ADDR_FLAGS, 32'h2);
    wrt(stm_pkg::ADDR_CTRL0, 8'h98);
    bus(1'b0, stm_pkg::ADDR_CNT_LO, 8'h00);
    q2 = q;
    rdk("paused", stm_pkg::ADDR_CNT_LO, q2);
    wrt(stm_pkg::ADDR_CTRL0, 8'h18);
    bus(1'b0, stm_pkg::ADDR_CNT_LO, 8'h00);
    chk("resumed", q != q2, 1);
    wrt(stm_pkg::ADDR_CTRL0, 8'h10);
    bus(1'b0, stm_pkg::ADDR_CNT_LO, 8'h00);
    q2 = q;
    rdk("stopped", stm_pkg::ADDR_CNT_LO, q2);
    wrt(stm_pkg::ADDR_CTRL0, 8'h18);
    rdk("restart_hi", stm_pkg::ADDR_CNT_HI, 32'h0);
    bus(1'b0, stm_pkg::ADDR_CNT_LO, 8'h00);
    chk("restart_lo", q < 8, 1);
    // mode 10 with waveform or forced-active pin code
    for (int k = 0; k < 5; k++) begin
      cfg(c1s[k], as[k], ps[k], stm_pkg::CLK_SYS);
      wait_p(!c1s[k][1], n);
      wait_p(!c1s[k][1], n);
      h = 0;
      repeat (256) begin
        @(posedge clk);
        h += (pin === 1'b1);
      end
      chk("pwm_high", h, hs[k]);
      if (!c1s[k][1]) chk("pwm_period", n, 256);
    end
    // single pulse code, enable cleared by A match and by software
    cfg(8'hB8, 16'h0020, 8'h00, stm_pkg::CLK_SYS);
    @(posedge clk);
    chk("pulse_lead", pin, 1);
    wait_p(1'b0, n);
    @(posedge clk);
    chk("pulse_trail", pin, 0);
    rdk("auto_off", stm_pkg::ADDR_CTRL0, 32'h10);
    wrt(stm_pkg::ADDR_CTRL0, 8'h18);
    @(posedge clk);
    chk("pulse_again", pin, 1);
    wrt(stm_pkg::ADDR_CTRL0, 8'h10);
    @(posedge clk);
    chk("soft_end", pin, 0);
    end_of_test();
  end
  initial begin
    #9000000;
    errors++;
    end_of_test();
  end
endmodule
bind stm_timer stm_timer_assertions i_stm_timer_assertions (
  .CLK_IN, .RST_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN,
  .AVS_BYTEENABLE_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .HCLK_TICK_IN,
  .SUBCLK_TICK_IN, .TIMER_PIN_OUT, .TIMER_PIN_OE_OUT, .MATCH_A_PULSE_OUT,
  .MATCH_P_PULSE_OUT
);
